// ---- fmf_pkg.sv ----
// Purpose: Shared constants for the four-lane multiply-sum-accumulate filter
// Assumes: One 100 MHz clock, AXI4-Lite register access
// Notes:   Register offsets are byte addresses
// What this block does
// R1: Fractional format outputs upper sixteen accumulator bits
// R2: Integer format outputs lower sixteen bits, unrounded
// R3: Format, hold target, accumulate are registered first
// R4: Hold low: lane loads pixel and weight
// R5: Hold high, target low: weight kept
// R6: Hold high, target high: pixel kept
// R7: Unheld input registers always refresh each cycle
// R8: Accumulate low restarts with current sum
// R9: Restart in fractional format adds half LSB
// R10: Accumulate high adds sum, no rounding
// R11: Latch enable low copies result to output
// R12: Latch enable high holds output, accumulation continues
// R13: Drive enable low drives bus, else released
// R14: Controller picks format for current coefficients
// R15: Result reaches output five clocks after capture
// R16: Accumulator is 25-bit signed
// R17: Four 10-bit signed pixel inputs
// R18: Four 11-bit signed weight inputs
// R19: Four signed products summed sign-extended
// R20: Rounding one sits just below output LSB
package fmf_pkg;
  localparam int NUM_LANES = 4;
  localparam int PIX_W     = 10; // R17
  localparam int WGT_W     = 11; // R18
  localparam int PROD_W    = PIX_W + WGT_W;
  localparam int SUM_W     = PROD_W + 2;
  localparam int ACC_W     = 25; // R16
  localparam int OUT_W     = 16;
  localparam int FRAC_LSB  = ACC_W - OUT_W;
  localparam int ROUND_BIT = FRAC_LSB - 1; // R20
  localparam int LATENCY   = 5;
  localparam int PIPE_D    = LATENCY;

  localparam int         AXI_AW    = 4;
  localparam logic [3:0] OFF_CTRL  = 4'h0;
  localparam logic [3:0] OFF_RES   = 4'h4;
  localparam logic [3:0] OFF_ACC   = 4'h8;

  localparam int BIT_FORMAT_SELECT   = 0;
  localparam int BIT_TSEL   = 1;
  localparam int BIT_ACC    = 2;
  localparam int BIT_OUTPUT_LATCH_ENABLE_N_N = 3;
  localparam int BIT_OEN_N  = 4;
  localparam int BIT_HOLD   = 8;

  localparam logic [31:0] CTRL_RST = 32'h0000_0010;
  localparam logic [31:0] CTRL_WMASK = 32'h0000_0f1f;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : fmf_pkg

// ---- fmf_lane_if.sv ----
// Purpose: Carrier between the filter core and one multiplier lane
// Assumes: Same clock on both sides
// Notes:   Product is registered inside the lane
`timescale 1ns/1ps
interface fmf_lane_if
  import fmf_pkg::*;
();
  logic signed [PIX_W-1:0]  pix;
  logic signed [WGT_W-1:0]  wgt;
  logic                     hold;
  logic                     tsel;
  logic signed [PROD_W-1:0] prod;
  modport lane (input pix, input wgt, input hold, input tsel, output prod);
  modport core (output pix, output wgt, output hold, output tsel, input prod);
endinterface : fmf_lane_if

// ---- fmf_lane.sv ----
// Purpose: One lane: held input registers and a registered product
// Assumes: Pixel and weight come from logic on the same clock
// Notes:   At least one input register refreshes every cycle
`timescale 1ns/1ps
module fmf_lane
  import fmf_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  fmf_lane_if.lane  lp
);
  typedef struct packed {
    logic signed [PIX_W-1:0]  pix;
    logic signed [WGT_W-1:0]  wgt;
    logic signed [PROD_W-1:0] prod;
  } fmf_lane_s;

  fmf_lane_s st_r;
  fmf_lane_s st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (!lp.hold || !lp.tsel) begin // R4 R5 R7
      st_nxt.pix = lp.pix;
    end
    if (!lp.hold || lp.tsel) begin // R4 R6 R7
      st_nxt.wgt = lp.wgt;
    end
    st_nxt.prod = st_r.pix * st_r.wgt; // R19
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign lp.prod = st_r.prod;
endmodule : fmf_lane

// ---- fmf_sum.sv ----
// Purpose: Registered sign-extended sum of the lane products
// Assumes: Products arrive registered
// Notes:   Sum is wide enough for four full-scale products
`timescale 1ns/1ps
module fmf_sum
  import fmf_pkg::*;
(
  input  wire logic                                clk,
  input  wire logic                                rst_n,
  input  wire logic [NUM_LANES-1:0][PROD_W-1:0]    prods,
  output logic signed [SUM_W-1:0]                  sum
);
  typedef struct packed {
    logic signed [SUM_W-1:0] sum;
  } fmf_sum_s;

  fmf_sum_s st_r;
  fmf_sum_s st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.sum = '0;
    for (int i = 0; i < NUM_LANES; i++) begin
      st_nxt.sum = st_nxt.sum + SUM_W'(signed'(prods[i])); // R19
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sum = st_r.sum;
endmodule : fmf_sum

// ---- fmf_filter.sv ----
// Purpose: Four-lane multiply-sum-accumulate filter with AXI4-Lite control
// Assumes: Pixel and weight inputs come from same-clock logic
// Notes:   Output drive enable is a register bit, so it acts one clock late
//
// The AXI4-Lite register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module fmf_filter
  import fmf_pkg::*;
(
  input  wire logic                              clk,
  input  wire logic                              rst_n,
  input  wire logic                              s_axi_awvalid,
  output logic                                   s_axi_awready,
  input  wire logic [AXI_AW-1:0]                 s_axi_awaddr,
  input  wire logic [2:0]                        s_axi_awprot,
  input  wire logic                              s_axi_wvalid,
  output logic                                   s_axi_wready,
  input  wire logic [31:0]                       s_axi_wdata,
  input  wire logic [3:0]                        s_axi_wstrb,
  output logic                                   s_axi_bvalid,
  input  wire logic                              s_axi_bready,
  output logic [1:0]                             s_axi_bresp,
  input  wire logic                              s_axi_arvalid,
  output logic                                   s_axi_arready,
  input  wire logic [AXI_AW-1:0]                 s_axi_araddr,
  input  wire logic [2:0]                        s_axi_arprot,
  output logic                                   s_axi_rvalid,
  input  wire logic                              s_axi_rready,
  output logic [31:0]                            s_axi_rdata,
  output logic [1:0]                             s_axi_rresp,
  input  wire logic [NUM_LANES-1:0][PIX_W-1:0]   pixel_inputs,
  input  wire logic [NUM_LANES-1:0][WGT_W-1:0]   weight_inputs,
  output logic [OUT_W-1:0]                       output_word_o,
  output logic                                   output_word_oe
);
  typedef struct packed {
    logic                    awready;
    logic                    wready;
    logic                    aw_ok;
    logic                    w_ok;
    logic [AXI_AW-1:0]       aw_addr;
    logic [31:0]             w_data;
    logic [3:0]              w_strb;
    logic                    bvalid;
    logic [1:0]              bresp;
    logic                    arready;
    logic                    rvalid;
    logic [1:0]              rresp;
    logic [31:0]             rdata;
    logic [31:0]             ctrl;
    logic [PIPE_D-1:0]       format_select_p;
    logic [PIPE_D-1:0]       acc_p;
    logic [PIPE_D-1:0]       output_latch_enable_n_n_p;
    logic signed [ACC_W-1:0] acc; // R16
    logic [OUT_W-1:0]        sel;
    logic [OUT_W-1:0]        out;
    logic                    oe;
  } fmf_top_s;

  localparam logic signed [ACC_W-1:0] ROUND_ONE = ACC_W'(1) << ROUND_BIT;

  fmf_top_s                            st_r;
  fmf_top_s                            st_nxt;
  logic [NUM_LANES-1:0][PROD_W-1:0]    prods;
  logic signed [SUM_W-1:0]             sum;
  logic signed [ACC_W-1:0]             sum_ext;
  logic [3:0]                          wr_byte;

  fmf_lane_if lanes [NUM_LANES] ();

  for (genvar g = 0; g < NUM_LANES; g++) begin : g_lane
    assign lanes[g].pix  = pixel_inputs[g];
    assign lanes[g].wgt  = weight_inputs[g];
    assign lanes[g].hold = st_r.ctrl[BIT_HOLD+g];
    assign lanes[g].tsel = st_r.ctrl[BIT_TSEL];
    assign prods[g]      = lanes[g].prod;
    fmf_lane u_lane (
      .clk   (clk),
      .rst_n (rst_n),
      .lp    (lanes[g])
    );
  end

  fmf_sum u_sum (
    .clk   (clk),
    .rst_n (rst_n),
    .prods (prods),
    .sum   (sum)
  );

  assign sum_ext = ACC_W'(sum); // R19

  always_comb begin
    st_nxt = st_r;

    // Write channel: address and data may arrive in either order
    if (s_axi_awvalid && st_r.awready) begin
      st_nxt.aw_ok   = 1'b1;
      st_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_r.wready) begin
      st_nxt.w_ok   = 1'b1;
      st_nxt.w_data = s_axi_wdata;
      st_nxt.w_strb = s_axi_wstrb;
    end
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    wr_byte = '0;
    if (st_r.aw_ok && st_r.w_ok && !st_r.bvalid) begin
      st_nxt.aw_ok  = 1'b0;
      st_nxt.w_ok   = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp  = RESP_OKAY;
      case (st_r.aw_addr)
        OFF_CTRL: wr_byte = st_r.w_strb;
        OFF_RES, OFF_ACC: wr_byte = '0;
        default: st_nxt.bresp = RESP_SLVERR;
      endcase
    end
    for (int b = 0; b < 4; b++) begin
      if (wr_byte[b]) begin
        st_nxt.ctrl[8*b +: 8] = st_r.w_data[8*b +: 8] & CTRL_WMASK[8*b +: 8];
      end
    end
    // Ready only while the slot is free, so nothing is taken twice
    st_nxt.awready = !st_nxt.aw_ok && !st_nxt.bvalid;
    st_nxt.wready  = !st_nxt.w_ok && !st_nxt.bvalid;

    // Read channel: one read in flight, answer one clock after the address
    if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st_r.arready) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp  = RESP_OKAY;
      case (s_axi_araddr)
        OFF_CTRL: st_nxt.rdata = st_r.ctrl;
        OFF_RES:  st_nxt.rdata = {{(32-OUT_W){1'b0}}, st_r.out};
        OFF_ACC:  st_nxt.rdata = 32'(st_r.acc);
        default: begin
          st_nxt.rdata = '0;
          st_nxt.rresp = RESP_SLVERR;
        end
      endcase
    end
    st_nxt.arready = !st_nxt.rvalid;

    // Controls travel with the data they were captured with
    st_nxt.format_select_p   = {st_r.format_select_p[PIPE_D-2:0], st_r.ctrl[BIT_FORMAT_SELECT]}; // R3
    st_nxt.acc_p    = {st_r.acc_p[PIPE_D-2:0], st_r.ctrl[BIT_ACC]}; // R3
    st_nxt.output_latch_enable_n_n_p = {st_r.output_latch_enable_n_n_p[PIPE_D-2:0], st_r.ctrl[BIT_OUTPUT_LATCH_ENABLE_N_N]};

    // Accumulator stage, third edge after capture
    if (st_r.acc_p[2]) begin
      st_nxt.acc = st_r.acc + sum_ext; // R10
    end else if (!st_r.format_select_p[2]) begin
      st_nxt.acc = sum_ext + ROUND_ONE; // R8 R9 R20
    end else begin
      st_nxt.acc = sum_ext; // R8 R2
    end

    // Bit selection, fourth edge
    if (st_r.format_select_p[3]) begin
      st_nxt.sel = st_r.acc[OUT_W-1:0]; // R2
    end else begin
      st_nxt.sel = st_r.acc[ACC_W-1:FRAC_LSB]; // R1
    end

    // Output register, fifth edge; accumulation above runs regardless
    if (!st_r.output_latch_enable_n_n_p[4]) begin
      st_nxt.out = st_r.sel; // R11 R15
    end // R12

    st_nxt.oe = !st_r.ctrl[BIT_OEN_N]; // R13
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r         <= '0;
      st_r.ctrl    <= CTRL_RST;
      st_r.awready <= 1'b1;
      st_r.wready  <= 1'b1;
      st_r.arready <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign s_axi_awready  = st_r.awready;
  assign s_axi_wready   = st_r.wready;
  assign s_axi_bvalid   = st_r.bvalid;
  assign s_axi_bresp    = st_r.bresp;
  assign s_axi_arready  = st_r.arready;
  assign s_axi_rvalid   = st_r.rvalid;
  assign s_axi_rdata    = st_r.rdata;
  assign s_axi_rresp    = st_r.rresp;
  assign output_word_o  = st_r.out;
  assign output_word_oe = st_r.oe; // R13
endmodule : fmf_filter

// ---- fmf_filter_checker.sv ----
// Purpose: Port checks for the filter
// Assumes: Full-word writes
// Notes:   Shadows CTRL, mirrors datapath
`timescale 1ns/1ps
module fmf_filter_checker
  import fmf_pkg::*;
(
  input wire logic                            clk,
  input wire logic                            rst_n,
  input wire logic                            s_axi_awvalid,
  input wire logic                            s_axi_awready,
  input wire logic [AXI_AW-1:0]               s_axi_awaddr,
  input wire logic                            s_axi_wvalid,
  input wire logic                            s_axi_wready,
  input wire logic [31:0]                     s_axi_wdata,
  input wire logic [NUM_LANES-1:0][PIX_W-1:0] pixel_inputs,
  input wire logic [NUM_LANES-1:0][WGT_W-1:0] weight_inputs,
  input wire logic [OUT_W-1:0]                output_word_o,
  input wire logic                            output_word_oe
);
  logic [31:0]                     ctl_r, wd_r;
  logic [AXI_AW-1:0]               ad_r;
  logic                            ga_r, gw_r;
  logic [NUM_LANES-1:0][PIX_W-1:0] pm_r;
  logic [NUM_LANES-1:0][WGT_W-1:0] wm_r;
  logic [3:0]                      c0_r, c3_r, c4_r, c5_r;
  logic [ACC_W+3:0]                q1_r, q2_r;
  logic signed [ACC_W-1:0]         sum_c, acc_r;
  logic [OUT_W-1:0]                sel_r, mo_r;
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_n);
  always_comb begin
    logic signed [PROD_W-1:0] p;
    p = '0;
    sum_c = '0;
    for (int i = 0; i < NUM_LANES; i++) begin
      p = $signed(pm_r[i]) * $signed(wm_r[i]);
      sum_c = sum_c + p;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_r <= CTRL_RST;
      {wd_r, ad_r, ga_r, gw_r, pm_r, wm_r, c0_r, c3_r, c4_r, c5_r} <= '0;
      {q1_r, q2_r, acc_r, sel_r, mo_r} <= '0;
    end else begin
      // Commit one edge after both halves, as the slave does
      if (ga_r && gw_r) begin
        if (ad_r == OFF_CTRL) ctl_r <= wd_r & CTRL_WMASK;
        {ga_r, gw_r} <= 2'h0;
      end else begin
        if (s_axi_awvalid && s_axi_awready) {ga_r, ad_r} <= {1'b1, s_axi_awaddr};
        if (s_axi_wvalid && s_axi_wready) {gw_r, wd_r} <= {1'b1, s_axi_wdata};
      end
      for (int i = 0; i < NUM_LANES; i++) begin
        if (!(ctl_r[BIT_HOLD+i] && ctl_r[BIT_TSEL])) pm_r[i] <= pixel_inputs[i];
        if (!(ctl_r[BIT_HOLD+i] && !ctl_r[BIT_TSEL])) wm_r[i] <= weight_inputs[i];
      end
      c0_r <= ctl_r[3:0];
      q1_r <= {c0_r, sum_c};
      q2_r <= q1_r;
      if (q2_r[ACC_W+BIT_ACC]) acc_r <= acc_r + q2_r[ACC_W-1:0];
      else if (q2_r[ACC_W+BIT_FORMAT_SELECT]) acc_r <= q2_r[ACC_W-1:0];
      else acc_r <= q2_r[ACC_W-1:0] + (25'h1 << ROUND_BIT);
      c3_r <= q2_r[ACC_W+3:ACC_W];
      sel_r <= c3_r[BIT_FORMAT_SELECT] ? acc_r[OUT_W-1:0] : acc_r[ACC_W-1:FRAC_LSB];
      c4_r <= c3_r;
      if (!c4_r[BIT_OUTPUT_LATCH_ENABLE_N_N]) mo_r <= sel_r;
      c5_r <= c4_r;
    end
  end
  property p_frac_out;
    !c5_r[BIT_FORMAT_SELECT] |-> output_word_o == mo_r;
  endproperty
  a_frac_out: assert property (p_frac_out) else $error("fraction output wrong");
  property p_int_out;
    c5_r[BIT_FORMAT_SELECT] |-> output_word_o == mo_r;
  endproperty
  a_int_out: assert property (p_int_out) else $error("integer output wrong");
  property p_round;
    !c5_r[BIT_ACC] && !c5_r[BIT_FORMAT_SELECT] |-> output_word_o == mo_r;
  endproperty
  a_round: assert property (p_round) else $error("rounding wrong");
  property p_accum;
    c5_r[BIT_ACC] |-> output_word_o == mo_r;
  endproperty
  a_accum: assert property (p_accum) else $error("accumulate wrong");
  property p_latch_load;
    !c5_r[BIT_OUTPUT_LATCH_ENABLE_N_N] && mo_r != $past(mo_r) |-> output_word_o != $past(output_word_o);
  endproperty
  a_latch_load: assert property (p_latch_load) else $error("output not loaded");
  property p_latch_hold;
    c5_r[BIT_OUTPUT_LATCH_ENABLE_N_N] |-> $stable(output_word_o);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("output not held");
  property p_drive;
    output_word_oe == !$past(ctl_r[BIT_OEN_N]);
  endproperty
  a_drive: assert property (p_drive) else $error("drive enable wrong");
  property p_lane_hold;
    ctl_r[11:8] != 4'h0 ##6 1'b1 |-> output_word_o == mo_r;
  endproperty
  a_lane_hold: assert property (p_lane_hold) else $error("lane hold wrong");
  c_accum: cover property (c5_r[BIT_ACC] && !c5_r[BIT_OUTPUT_LATCH_ENABLE_N_N]);
  c_hold_out: cover property (c5_r[BIT_OUTPUT_LATCH_ENABLE_N_N]);
  c_hold_pix: cover property (ctl_r[11:8] == 4'hf && ctl_r[BIT_TSEL]);
endmodule : fmf_filter_checker
bind fmf_filter fmf_filter_checker chk_u (
  .clk            (clk),
  .rst_n          (rst_n),
  .s_axi_awvalid  (s_axi_awvalid),
  .s_axi_awready  (s_axi_awready),
  .s_axi_awaddr   (s_axi_awaddr),
  .s_axi_wvalid   (s_axi_wvalid),
  .s_axi_wready   (s_axi_wready),
  .s_axi_wdata    (s_axi_wdata),
  .pixel_inputs   (pixel_inputs),
  .weight_inputs  (weight_inputs),
  .output_word_o  (output_word_o),
  .output_word_oe (output_word_oe)
);

// ---- fmf_feeder.sv ----
// Purpose: Pixel and weight source for the filter
// Assumes: Launches words on the edge after they are chosen
// Notes:   Same word on every lane keeps expectations simple
`timescale 1ns/1ps
module fmf_feeder
  import fmf_pkg::*;
(
  input  wire logic                            clk,
  input  wire logic                            rst_n,
  input  wire logic [PIX_W-1:0]                pix_nxt,
  input  wire logic [WGT_W-1:0]                wgt_nxt,
  output logic      [NUM_LANES-1:0][PIX_W-1:0] pixel_inputs,
  output logic      [NUM_LANES-1:0][WGT_W-1:0] weight_inputs
);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pixel_inputs  <= '0;
      weight_inputs <= '0;
    end else begin
      pixel_inputs  <= {NUM_LANES{pix_nxt}};
      weight_inputs <= {NUM_LANES{wgt_nxt}};
    end
  end
endmodule : fmf_feeder

// ---- testbench.sv ----
// Purpose: Self-checking bench for the filter
// Assumes: CTRL at 0x0, results read in steady state
// Notes:   Exact cycle timing is left to the checker
`timescale 1ns/1ps
module testbench
  import fmf_pkg::*;
;
  typedef struct packed {
    logic [31:0] ctl;
    logic [9:0]  pix;
    logic [10:0] wgt;
    logic [15:0] exp;
  } fmf_row_s;
  logic clk = 1'b0, rst_n = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, output_word_oe;
  logic [3:0] s_axi_awaddr = '0, s_axi_araddr = '0, s_axi_wstrb = 4'hf;
  logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, d, a1;
  logic [9:0]  pix_nxt = '0;
  logic [10:0] wgt_nxt = '0;
  logic [15:0] output_word_o, o1;
  logic [3:0][9:0]  pixel_inputs;
  logic [3:0][10:0] weight_inputs;
  int err_count = 0, checked = 0;
  fmf_row_s rows [8] = '{
    '{32'h001, 10'h003, 11'h005, 16'h003c},
    '{32'h001, 10'h3fe, 11'h007, 16'hffc8},
    '{32'h000, 10'h1ff, 11'h3ff, 16'h0ff4},
    '{32'h001, 10'h1ff, 11'h3ff, 16'he804},
    '{32'h001, 10'h002, 11'h003, 16'h0018},
    '{32'hf01, 10'h005, 11'h064, 16'h003c},
    '{32'hf03, 10'h009, 11'h064, 16'h07d0},
    '{32'h001, 10'h009, 11'h064, 16'h0e10}};
  always #5 clk = ~clk;
  fmf_filter dut_u (
    .clk            (clk),
    .rst_n          (rst_n),
    .s_axi_awvalid  (s_axi_awvalid),
    .s_axi_awready  (s_axi_awready),
    .s_axi_awaddr   (s_axi_awaddr),
    .s_axi_awprot   (s_axi_awprot),
    .s_axi_wvalid   (s_axi_wvalid),
    .s_axi_wready   (s_axi_wready),
    .s_axi_wdata    (s_axi_wdata),
    .s_axi_wstrb    (s_axi_wstrb),
    .s_axi_bvalid   (s_axi_bvalid),
    .s_axi_bready   (s_axi_bready),
    .s_axi_bresp    (s_axi_bresp),
    .s_axi_arvalid  (s_axi_arvalid),
    .s_axi_arready  (s_axi_arready),
    .s_axi_araddr   (s_axi_araddr),
    .s_axi_arprot   (s_axi_arprot),
    .s_axi_rvalid   (s_axi_rvalid),
    .s_axi_rready   (s_axi_rready),
    .s_axi_rdata    (s_axi_rdata),
    .s_axi_rresp    (s_axi_rresp),
    .pixel_inputs   (pixel_inputs),
    .weight_inputs  (weight_inputs),
    .output_word_o  (output_word_o),
    .output_word_oe (output_word_oe)
  );
  fmf_feeder feed_u (
    .clk           (clk),
    .rst_n         (rst_n),
    .pix_nxt       (pix_nxt),
    .wgt_nxt       (wgt_nxt),
    .pixel_inputs  (pixel_inputs),
    .weight_inputs (weight_inputs)
  );
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    {s_axi_awaddr, s_axi_wdata} <= {a, v};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    // One idle edge so back-to-back calls never drive a signal twice at once
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    {v, r} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask : rd
  task automatic test_done();
    $display("errors %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done
  // Whole run is well under a thousand cycles
  initial begin
    #20000;
    err_count++;
    test_done();
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk({31'h0, output_word_oe}, 32'h0, "drive after reset");
    rd(OFF_CTRL, d);
    chk(d, CTRL_RST, "ctrl reset");
    rd(4'hc, d);
    chk({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped read");
    wr(OFF_RES, CTRL_WMASK);
    chk({30'h0, r}, {30'h0, RESP_OKAY}, "ignored write");
    wr(4'hc, 32'h0);
    chk({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped write");
    rd(OFF_CTRL, d);
    chk(d, CTRL_RST, "ctrl untouched");
    foreach (rows[i]) begin
      wr(OFF_CTRL, rows[i].ctl);
      chk({30'h0, r}, {30'h0, RESP_OKAY}, "write response");
      {pix_nxt, wgt_nxt} <= {rows[i].pix, rows[i].wgt};
      repeat (12) @(posedge clk);
      chk({16'h0, output_word_o}, {16'h0, rows[i].exp}, "row output");
      rd(OFF_RES, d);
      chk(d, {16'h0, rows[i].exp}, "row result");
      chk({31'h0, output_word_oe}, 32'h1, "row drive");
    end
    {pix_nxt, wgt_nxt} <= {10'h001, 11'h001};
    wr(OFF_CTRL, 32'h005);
    repeat (12) @(posedge clk);
    o1 = output_word_o;
    repeat (10) @(posedge clk);
    chk({16'h0, output_word_o - o1}, 32'h28, "accumulate step");
    wr(OFF_CTRL, 32'h00c);
    repeat (8) @(posedge clk);
    o1 = output_word_o;
    rd(OFF_ACC, a1);
    rd(OFF_ACC, d);
    chk({16'h0, output_word_o}, {16'h0, o1}, "output held");
    // Three edges between the two reads, four added each, no rounding
    chk(d - a1, 32'hc, "accumulator runs");
    wr(OFF_CTRL, 32'h011);
    repeat (2) @(posedge clk);
    chk({31'h0, output_word_oe}, 32'h0, "bus released");
    // Mid-run reset: outputs clear at once, control word returns
    rst_n <= 1'b0;
    @(posedge clk);
    chk({15'h0, output_word_o, output_word_oe}, 32'h0, "outputs in reset");
    chk({30'h0, s_axi_bvalid, s_axi_rvalid}, 32'h0, "no answer in reset");
    rst_n <= 1'b1;
    @(posedge clk);
    rd(OFF_CTRL, d);
    chk(d, CTRL_RST, "ctrl after reset");
    test_done();
  end
endmodule : testbench
